// File: hdl/adgain_pkg.sv
// package: register map, reset values, gain tables and carriers
package adgain_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_QUAD = 8'h2A;
    localparam logic [7:0] IDX_DUAL = 8'h2B;
    localparam logic [7:0] IDX_CFG = 8'h33;
    localparam logic [7:0] IDX_TRIM0 = 8'h34;
    localparam logic [7:0] IDX_TRIM1 = 8'h35;
    localparam logic [7:0] IDX_TRIM2 = 8'h36;
    localparam logic [7:0] IDX_TRIM3 = 8'h37;
    localparam logic [7:0] IDX_MODE = 8'h38;
    localparam logic [7:0] IDX_STAT = 8'h39;
    localparam logic [7:0] IDX_SATCNT = 8'h3A;

    // ==========================================================
    // reset values and writable bits
    localparam logic [15:0] QUAD_RST = 16'h0000;
    localparam logic [15:0] DUAL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0001;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] SATCNT_RST = 16'h0000;
    localparam logic [15:0] QUAD_MASK = 16'hFFFF;
    localparam logic [15:0] DUAL_MASK = 16'h0FFF;
    localparam logic [15:0] CFG_MASK = 16'h0003;
    localparam logic [15:0] TRIM_MASK = 16'h7F7F;
    localparam logic [15:0] MODE_MASK = 16'h0003;

    // ==========================================================
    // field positions
    localparam int CFG_TABLE_BIT = 0;
    localparam int CFG_TRIM_BIT = 1;
    localparam int SINGLE_LSB = 8;
    localparam int TRIM_HI_LSB = 8;
    localparam int STAT_SAT_BIT = 0;
    localparam int STAT_LVL_LSB = 1;
    localparam int BUF_DEPTH = 2;

    // ==========================================================
    // channel modes, gray along quad, dual, single
    typedef enum logic [1:0] {
        MODE_QUAD = 2'h0,
        MODE_DUAL = 2'h1,
        MODE_SINGLE = 2'h3
    } adgain_mode_e;

    // ==========================================================
    // gains as unsigned q8 (coarse) and q13 (fine) factors
    localparam logic [14:0] COARSE_UNITY = 15'h0100;
    localparam logic [14:0] FINE_UNITY = 15'h2000;
    localparam logic [14:0] DB_TAB [0:12] = '{
        15'h0100, 15'h011F, 15'h0142, 15'h016A, 15'h0196, 15'h01C7,
        15'h01FF, 15'h023D, 15'h0283, 15'h02D1, 15'h032A, 15'h038C,
        15'h03FB};
    localparam logic [14:0] LIN_TAB [0:13] = '{
        15'h0100, 15'h0140, 15'h0200, 15'h0280, 15'h0400, 15'h0500,
        15'h0800, 15'h0A00, 15'h0C80, 15'h1000, 15'h1400, 15'h1900,
        15'h2000, 15'h3200};
    localparam logic [3:0] DB_LAST = 4'hC;
    localparam logic [3:0] LIN_LAST = 4'hD;

    // coarse code to factor; unused codes fall back to unity
    function automatic logic [14:0] adgain_coarse(input logic lin,
                                                  input logic [3:0] c);
        logic [14:0] f;
        f = COARSE_UNITY;
        if (lin && c <= LIN_LAST) begin
            f = LIN_TAB[c];
        end else if (!lin && c <= DB_LAST) begin
            f = DB_TAB[c];
        end
        return f;
    endfunction

    // fine code: sign bit picks add or ones-complement subtract
    function automatic logic [14:0] adgain_fine(input logic [6:0] c);
        logic [14:0] f;
        f = c[6] ? 15'(FINE_UNITY - {9'h000, ~c[5:0]})
                 : 15'(FINE_UNITY + {9'h000, c[5:0]});
        return f;
    endfunction

    // ==========================================================
    // stream carriers
    typedef struct packed {
        logic [7:0] data;
        logic [2:0] branch;
        logic [1:0] chan;
    } adgain_smp_s;

    typedef struct packed {
        logic [7:0] data;
        logic [1:0] chan;
        logic sat;
    } adgain_res_s;

endpackage

// File: hdl/adgain_mult.sv
// module: combinational coarse and fine gain with saturation
`timescale 1ns/100ps
module adgain_mult import adgain_pkg::*; (
    input wire logic [7:0] din,
    input wire logic [14:0] coarse,
    input wire logic [14:0] fine,
    output logic [7:0] dout,
    output logic sat
);
    logic signed [7:0] s8;
    logic signed [39:0] prod;
    logic signed [39:0] rnd;
    logic signed [18:0] q;

    // offset binary in; 21 fraction bits kept until the final round
    always_comb begin
        s8 = $signed({~din[7], din[6:0]});
        prod = s8 * $signed({1'b0, coarse}) * $signed({1'b0, fine}); // RULE_04
        rnd = prod + 40'sh0000100000;
        q = rnd[39:21];
        sat = (q > 19'sh0007F) || (q < -19'sh00080);
        if (q > 19'sh0007F) begin
            dout = 8'hFF; // RULE_13
        end else if (q < -19'sh00080) begin
            dout = 8'h00; // RULE_13
        end else begin
            dout = {~q[7], q[6:0]};
        end
    end
endmodule

// File: hdl/adgain_buf.sv
// module: two-entry result buffer, all outputs from flops
`timescale 1ns/100ps
module adgain_buf import adgain_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire adgain_res_s in_data,
    output logic out_valid,
    input wire logic out_ready,
    output adgain_res_s out_data,
    output logic [1:0] level
);
    adgain_res_s spare_r;
    logic [1:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign cnt_nxt = 2'(level + {1'b0, push} - {1'b0, pop});

    // occupancy and the handshake flags, registered from next count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 2'h0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            level <= cnt_nxt;
            in_ready <= (cnt_nxt != 2'(BUF_DEPTH));
            out_valid <= (cnt_nxt != 2'h0);
        end
    end

    // head entry drives the output; spare soaks up a stall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data <= '0;
            spare_r <= '0;
        end else begin
            if (pop && level == 2'h2) begin
                out_data <= spare_r;
            end else if (push && (level == 2'h0 || pop)) begin
                out_data <= in_data;
            end
            if (push && ((level == 2'h1 && !pop) || level == 2'h2)) begin
                spare_r <= in_data;
            end
        end
    end
endmodule

// File: hdl/adgain_top.sv
// module: digital gain stage with apb registers and stream buffer
//
// Overview of operation
// RULE_01 - each output channel has its own four-bit coarse gain code.
// RULE_02 - config bit 0 picks dB steps (0) or linear factors (1), reset 1.
// RULE_03 - in dB mode codes 0 to 12 give 0 to 12 dB, 13 to 15 unused.
// RULE_04 - the product keeps fraction bits so low gains miss no codes.
// RULE_05 - config bit 1 enables fine trim, reset off, off means unity.
// RULE_06 - the quad register holds four nibbles, channel 1 lowest.
// RULE_07 - the dual register holds channel 1 and 2 in its low byte.
// RULE_08 - the single-mode code sits in bits 11 to 8 of the dual register.
// RULE_09 - eight seven-bit trims sit two per register, odd branch low; the code puts the odd branch in the high field.
// RULE_10 - in linear mode codes 0 to 13 map to 1x through 50x.
// RULE_11 - trim scales by one plus or minus weights 2^-8 to 2^-13.
// RULE_12 - the channel mode picks which coarse field is applied.
// RULE_13 - results past eight bits clamp to the nearest full scale.
`timescale 1ns/100ps
module adgain_top import adgain_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic s_valid,
    output logic s_ready,
    input wire adgain_smp_s s_smp,
    output logic m_valid,
    input wire logic m_ready,
    output adgain_res_s m_res
);

    // ==========================================================
    // helpers

    // byte-lane merge of a 16-bit register under its writable mask
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] strb,
                                          input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lanes) | (wd & lanes);
    endfunction

    // one four-bit code out of a packed word
    function automatic logic [3:0] nib(input logic [15:0] w,
                                       input logic [1:0] i);
        return w[{i, 2'b00} +: 4];
    endfunction

    // ==========================================================
    // declarations

    logic [15:0] quad_r;
    logic [15:0] dual_r;
    logic [15:0] cfg_r;
    logic [15:0] trim_r [0:3];
    logic [1:0] mode_r;
    logic sat_sticky_r;
    logic [15:0] sat_cnt_r;
    logic [7:0] idx;
    logic aligned;
    logic hit;
    logic [15:0] rd_val;
    logic wr_en;
    logic wr_stat;
    logic wr_cnt;
    logic [3:0] coarse_code;
    logic [15:0] trim_word;
    logic [6:0] trim_code;
    logic [14:0] coarse_f;
    logic [14:0] fine_f;
    logic [7:0] gain_out;
    logic gain_sat;
    logic take;
    logic sat_evt;
    adgain_res_s res;
    logic [1:0] buf_level;

    // ==========================================================
    // apb decode

    // word index; low address bits must be zero for a legal access
    assign idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00);

    // a write lands only at the completing edge of the access phase
    assign wr_en = psel && penable && pready && pwrite && aligned && hit;
    assign wr_stat = wr_en && idx == IDX_STAT && pstrb[0];
    assign wr_cnt = wr_en && idx == IDX_SATCNT && (|pstrb[1:0]);

    // read mux; reserved bits and unmapped words read zero
    always_comb begin
        rd_val = 16'h0000;
        hit = 1'b1;
        case (idx)
            IDX_QUAD: begin
                rd_val = quad_r;
            end
            IDX_DUAL: begin
                rd_val = dual_r;
            end
            IDX_CFG: begin
                rd_val = cfg_r;
            end
            IDX_TRIM0, IDX_TRIM1, IDX_TRIM2, IDX_TRIM3: begin
                rd_val = trim_r[idx[1:0]];
            end
            IDX_MODE: begin
                rd_val = {14'h0000, mode_r};
            end
            IDX_STAT: begin
                rd_val[STAT_SAT_BIT] = sat_sticky_r;
                rd_val[STAT_LVL_LSB +: 2] = buf_level;
            end
            IDX_SATCNT: begin
                rd_val = sat_cnt_r;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // zero wait states: pready rises for the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= (aligned && !pwrite) ? {16'h0000, rd_val}
                                           : 32'h00000000;
            pslverr <= !(aligned && hit);
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // gain registers

    // coarse codes for quad mode, four nibbles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_r <= QUAD_RST; // RULE_06
        end else if (wr_en && idx == IDX_QUAD) begin
            quad_r <= merge(quad_r, pwdata[15:0], pstrb[1:0],
                            QUAD_MASK); // RULE_06
        end
    end

    // dual-mode codes low byte, single-mode code in the third nibble
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_r <= DUAL_RST; // RULE_07 RULE_08
        end else if (wr_en && idx == IDX_DUAL) begin
            dual_r <= merge(dual_r, pwdata[15:0], pstrb[1:0],
                            DUAL_MASK); // RULE_07 RULE_08
        end
    end

    // table select and trim enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RST; // RULE_02 RULE_05
        end else if (wr_en && idx == IDX_CFG) begin
            cfg_r <= merge(cfg_r, pwdata[15:0], pstrb[1:0],
                           CFG_MASK); // RULE_02 RULE_05
        end
    end

    // branch trims, two seven-bit fields per word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                trim_r[i] <= TRIM_RST; // RULE_09
            end
        end else if (wr_en && idx[7:2] == IDX_TRIM0[7:2]) begin
            trim_r[idx[1:0]] <= merge(trim_r[idx[1:0]], pwdata[15:0],
                                      pstrb[1:0], TRIM_MASK); // RULE_09
        end
    end

    // channel mode; an unlisted code behaves as single mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RST;
        end else if (wr_en && idx == IDX_MODE && pstrb[0]) begin
            mode_r <= pwdata[1:0] & MODE_MASK[1:0];
        end
    end

    // ==========================================================
    // gain selection

    // mode decides which field drives the sample's channel
    always_comb begin
        case (mode_r)
            MODE_QUAD: begin
                coarse_code = nib(quad_r, s_smp.chan); // RULE_12 RULE_01
            end
            MODE_DUAL: begin
                coarse_code = nib(dual_r, {1'b0, s_smp.chan[0]}); // RULE_12
            end
            default: begin
                coarse_code = dual_r[SINGLE_LSB +: 4]; // RULE_12 RULE_08
            end
        endcase
    end

    // branch n lives in word n/2; odd branch high, even branch low
    always_comb begin
        trim_word = trim_r[s_smp.branch[2:1]];
        trim_code = s_smp.branch[0] ? trim_word[TRIM_HI_LSB +: 7]
                                    : trim_word[6:0]; // RULE_09
    end

    // table lookup for both interpretations, unity fine when off
    assign coarse_f = adgain_coarse(cfg_r[CFG_TABLE_BIT],
                                    coarse_code); // RULE_02 RULE_03 RULE_10
    assign fine_f = cfg_r[CFG_TRIM_BIT] ? adgain_fine(trim_code)
                                        : FINE_UNITY; // RULE_05 RULE_11

    // ==========================================================
    // datapath

    // multiply is applied on top of the analog full-scale setting
    adgain_mult u_mult (
        .din(s_smp.data),
        .coarse(coarse_f),
        .fine(fine_f),
        .dout(gain_out),
        .sat(gain_sat)
    );

    // one sample per accepted handshake; the buffer stalls the source
    assign take = s_valid && s_ready;
    assign sat_evt = take && gain_sat;
    assign res.data = gain_out;
    assign res.chan = s_smp.chan;
    assign res.sat = gain_sat;

    // two entries so a stalled sink loses nothing
    adgain_buf u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(s_valid),
        .in_ready(s_ready),
        .in_data(res),
        .out_valid(m_valid),
        .out_ready(m_ready),
        .out_data(m_res),
        .level(buf_level)
    );

    // ==========================================================
    // saturation status

    // sticky flag, write one to clear; a new clip beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_sticky_r <= 1'b0;
        end else if (sat_evt) begin
            sat_sticky_r <= 1'b1; // RULE_13
        end else if (wr_stat && pwdata[STAT_SAT_BIT]) begin
            sat_sticky_r <= 1'b0;
        end
    end

    // clip counter, stops at all ones so it never wraps to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_cnt_r <= SATCNT_RST;
        end else if (wr_cnt) begin
            sat_cnt_r <= sat_evt ? 16'h0001 : SATCNT_RST;
        end else if (sat_evt && sat_cnt_r != 16'hFFFF) begin
            sat_cnt_r <= 16'(sat_cnt_r + 16'h0001);
        end
    end

endmodule

// File: testbench/adgain_top_checker.sv
// checker: bus and stream assertions on the gain stage ports
`timescale 1ns/100ps
module adgain_top_checker import adgain_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic s_valid,
    input wire logic s_ready,
    input wire adgain_smp_s s_smp,
    input wire logic m_valid,
    input wire logic m_ready,
    input wire adgain_res_s m_res
);
    // ==========================================================
    // one domain, so clock and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // register bus
    property p_ready_first;
        psel && !penable |=> pready;
    endproperty
    a_ready_first: assert property (p_ready_first)
        else $error("pready missing in first access cycle");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");
    property p_upper_zero;
        pready |-> prdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read data not zero");
    property p_unaligned;
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && pready;
    endproperty
    a_unaligned: assert property (p_unaligned)
        else $error("unaligned access not refused");
    property p_err_zero;
        pready && pslverr |-> prdata == 32'h00000000;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused access returned data");

    // ==========================================================
    // stream: answer, hold, clamp, back pressure
    property p_take_answer;
        s_valid && s_ready && !m_valid |=>
            m_valid && m_res.chan == $past(s_smp.chan);
    endproperty
    a_take_answer: assert property (p_take_answer)
        else $error("result missing one cycle after take");
    property p_hold;
        m_valid && !m_ready |=> m_valid && $stable(m_res);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed while stalled");
    property p_clamp;
        m_valid && m_res.sat |-> m_res.data == 8'h00 || m_res.data == 8'hFF;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("clipped result not at full scale");
    // two takes with no drain leave both entries occupied
    sequence s_two_takes;
        (s_valid && s_ready && !m_valid) ##1 (s_valid && s_ready && !m_ready);
    endsequence
    property p_full;
        s_two_takes |=> !s_ready;
    endproperty
    a_full: assert property (p_full)
        else $error("input still ready with buffer full");

    // ==========================================================
    // scenario coverage
    c_write: cover property (psel && penable && pready && pwrite);
    c_clip: cover property (m_valid && m_ready && m_res.sat);
    c_full: cover property (m_valid && !s_ready);
endmodule

// File: testbench/adgain_top_tb.sv
// testbench: register checks and gain stream against a bench model
`timescale 1ns/100ps
module adgain_top_tb import adgain_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic s_valid, s_ready, m_valid;
    logic m_ready = 1'b0;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [3:0] pstrb;
    adgain_smp_s s_smp;
    adgain_res_s m_res;
    int errors, checks_done, cyc, sats;
    logic [15:0] mr [256];
    logic [15:0] mk [256];
    logic [10:0] expq [$];
    logic [7:0] regs [9] = '{IDX_QUAD, IDX_DUAL, IDX_CFG, IDX_TRIM0,
        IDX_TRIM1, IDX_TRIM2, IDX_TRIM3, IDX_MODE, 8'h10};
    int db [13] = '{256, 287, 322, 362, 406, 455, 511, 573, 643, 721, 810,
        908, 1019};
    int lin [14] = '{256, 320, 512, 640, 1024, 1280, 2048, 2560, 3200,
        4096, 5120, 6400, 8192, 12800};

    adgain_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .s_valid(s_valid), .s_ready(s_ready), .s_smp(s_smp),
        .m_valid(m_valid), .m_ready(m_ready), .m_res(m_res));

    // ==========================================================
    // clock, sink stalls of eight cycles to fill the buffer
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        m_ready <= presetn && cyc[4:3] != 2'h3;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // bench model of one sample, from the current register copy
    function automatic logic [10:0] model(adgain_smp_s x);
        logic [3:0] c;
        logic [6:0] t;
        logic [5:0] tn;
        longint p;
        int cc, fc;
        c = mr[IDX_MODE][1:0] == 2'h0 ? 4'(mr[IDX_QUAD] >> (4 * x.chan)) :
            mr[IDX_MODE][1:0] == 2'h1 ? 4'(mr[IDX_DUAL] >> (4 * x.chan[0])) :
            mr[IDX_DUAL][11:8];
        if (mr[IDX_CFG][0]) begin
            cc = c <= 13 ? lin[c] : 256;
        end else begin
            cc = c <= 12 ? db[c] : 256;
        end
        t = 7'(mr[IDX_TRIM0 + x.branch[2:1]] >> (8 * x.branch[0]));
        // invert at six bits so the cast cannot widen it first
        tn = ~t[5:0];
        fc = !mr[IDX_CFG][1] ? 8192 :
            t[6] ? 8192 - int'(tn) : 8192 + int'(t[5:0]);
        p = longint'($signed(x.data ^ 8'h80)) * cc * fc;
        p = (p + 1048576) >>> 21;
        if (p > 127) return {8'hFF, x.chan, 1'b1};
        if (p < -128) return {8'h00, x.chan, 1'b1};
        return {8'(p) ^ 8'h80, x.chan, 1'b0};
    endfunction

    // ==========================================================
    // comparison, verdict and bus tasks
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic expired();
        errors++;
        $display("ERROR t=%0t wait expired got=%h exp=%h", $time, 0, 1);
        give_verdict();
    endtask
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [15:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic err);
        logic ok;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {16'h0000, wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // answer taken at the rising edge that sees pready high
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            ok = pready;
            rd = prdata;
            err = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) expired();
    endtask
    // write, mirror into the model copy, read back
    task automatic wr(input logic [7:0] idx, input logic [15:0] v,
                      input logic [3:0] st);
        logic [31:0] r;
        logic e;
        logic [15:0] k;
        apb(1'b1, idx, v, st, r, e);
        k = {{8{st[1]}}, {8{st[0]}}} & mk[idx];
        mr[idx] = (mr[idx] & ~k) | (v & k);
        apb(1'b0, idx, 16'h0000, 4'h0, r, e);
        chk(r, {16'h0000, mr[idx]});
        chk({31'h0, e}, {31'h0, idx == 8'h10});
    endtask
    // stream samples back to back, model result queued at each take
    task automatic send(input int cnt);
        logic ok;
        logic [10:0] res;
        @(posedge pclk);
        for (int i = 0; i < cnt; i++) begin
            s_valid <= 1'b1;
            s_smp <= 13'(rnd());
            ok = 1'b0;
            for (int n = 0; n < 40 && !ok; n++) begin
                @(negedge pclk);
                ok = s_ready;
                if (ok) begin
                    res = model(s_smp);
                    expq.push_back(res);
                    sats += int'(res[0]);
                end
                @(posedge pclk);
            end
            if (!ok) expired();
        end
        s_valid <= 1'b0;
        for (int n = 0; n < 200 && expq.size() > 0; n++) @(posedge pclk);
        if (expq.size() > 0) expired();
    endtask

    // every delivered result against the model queue, empty gives x
    always @(negedge pclk) begin
        if (presetn && m_valid && m_ready) begin
            chk({21'h0, m_res}, {21'h0, expq.size() ? expq.pop_front()
                : 11'hXXX});
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        {psel, penable, pwrite, s_valid, presetn} = 5'h00;
        {paddr, pwdata, pstrb, s_smp} = '0;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        sats = 0;
        seed = 32'hE307;
        foreach (mr[i]) {mr[i], mk[i]} = 32'h00000000;
        {mr[IDX_QUAD], mr[IDX_DUAL], mr[IDX_CFG]} = {QUAD_RST, DUAL_RST,
            CFG_RST};
        for (int i = 3; i < 7; i++) {mr[regs[i]], mk[regs[i]]} =
            {TRIM_RST, TRIM_MASK};
        {mk[IDX_QUAD], mk[IDX_DUAL], mk[IDX_CFG]} = {QUAD_MASK, DUAL_MASK,
            CFG_MASK};
        {mr[IDX_MODE], mk[IDX_MODE]} = {14'h0, MODE_RST, MODE_MASK};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then lane-masked writes including unmapped
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 16'h0000, 4'h0, r, e);
            chk(r, {16'h0000, mr[regs[i]]});
        end
        repeat (2) foreach (regs[i]) begin
            wr(regs[i], 16'(rnd()), 4'(rnd()));
        end
        // every table, trim and channel mode code, including code 2
        for (int k = 0; k < 16; k++) begin
            wr(IDX_CFG, 16'(k % 4), 4'h3);
            wr(IDX_MODE, 16'(k / 4), 4'h3);
            for (int i = 0; i < 7; i++) begin
                if (i != 2) wr(regs[i], 16'(rnd()), 4'h3);
            end
            send(24);
            // clip count and sticky flag against the model, then clear
            apb(1'b0, IDX_SATCNT, 16'h0000, 4'h0, r, e);
            chk(r, 32'(sats));
            apb(1'b0, IDX_STAT, 16'h0000, 4'h0, r, e);
            chk(r, {31'h0, sats != 0});
            apb(1'b1, IDX_STAT, 16'h0001, 4'h1, r, e);
            apb(1'b1, IDX_SATCNT, 16'h0000, 4'h3, r, e);
            apb(1'b0, IDX_STAT, 16'h0000, 4'h0, r, e);
            chk(r, 32'h00000000);
            apb(1'b0, IDX_SATCNT, 16'h0000, 4'h0, r, e);
            chk(r, 32'h00000000);
            sats = 0;
        end
        give_verdict();
    end
endmodule

bind adgain_top adgain_top_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready),
    .s_smp(s_smp), .m_valid(m_valid), .m_ready(m_ready), .m_res(m_res));
